// ---- core/sidec_pkg.sv ----
package sidec_pkg;

	localparam int CYC_W = 10;
	localparam int CTX_W = 8;

	localparam logic [7:0] OP_CTRL_B0     = 8'h7b;
	localparam logic       OP_CTRL_B1_MSB = 1'b1;
	localparam logic [7:0] OP_PROG_B0     = 8'h7c;
	localparam logic [3:0] OP_PROG_B1_HI  = 4'hc;
	localparam logic [7:0] OP_CTX_B0      = 8'h7c;
	localparam logic [7:0] OP_CTX_B1      = 8'hf0;
	localparam logic [6:0] OP_EXT_B0_HI   = 7'h3a;
	localparam logic [3:0] OP_EXT_FAR     = 4'h0;
	localparam logic [3:0] OP_EXT_DSP20   = 4'h1;
	localparam logic [3:0] OP_EXT_PAIR    = 4'h2;
	localparam logic [4:0] OP_NZ_HI       = 5'h1a;
	localparam logic [4:0] OP_Z_HI        = 5'h19;

	localparam logic [2:0] CREG_RSVD      = 3'h0;
	localparam logic [2:0] CREG_VEC_LOW   = 3'h1;
	localparam logic [2:0] CREG_VEC_HIGH  = 3'h2;
	localparam logic [2:0] CREG_FLAGS     = 3'h3;
	localparam logic [2:0] CREG_INT_STK   = 3'h4;
	localparam logic [2:0] CREG_USR_STK   = 3'h5;
	localparam logic [2:0] CREG_STATIC    = 3'h6;
	localparam logic [2:0] CREG_FRAME     = 3'h7;

	localparam logic [3:0] DST_DATA_PAIR_LOW  = 4'h0;
	localparam logic [3:0] DST_DATA_PAIR_HIGH = 4'h1;
	localparam logic [3:0] DST_ADDRESS_PAIR   = 4'h4;
	localparam logic [3:0] CODE_FIRST_MEM     = 4'h6;

	localparam logic [2:0] CD_ACC_HIGH   = 3'h3;
	localparam logic [2:0] CD_ACC_LOW    = 3'h4;
	localparam logic [2:0] CD_STATIC_DSP = 3'h5;
	localparam logic [2:0] CD_FRAME_DSP  = 3'h6;
	localparam logic [2:0] CD_NEAR_ABS   = 3'h7;

	localparam logic [CYC_W-1:0] CYC_CTRL_REG   = 10'h001;
	localparam logic [CYC_W-1:0] CYC_CTRL_MEM   = 10'h002;
	localparam logic [CYC_W-1:0] CYC_PROG_REG   = 10'h002;
	localparam logic [CYC_W-1:0] CYC_PROG_MEM   = 10'h003;
	localparam logic [CYC_W-1:0] CYC_CTX_BASE   = 10'h00b;
	localparam logic [CYC_W-1:0] CYC_CTX_PER    = 10'h002;
	localparam logic [CYC_W-1:0] CYC_EXT_REG    = 10'h003;
	localparam logic [CYC_W-1:0] CYC_EXT_MEM    = 10'h004;
	localparam logic [CYC_W-1:0] CYC_COND_REG   = 10'h001;
	localparam logic [CYC_W-1:0] CYC_COND_MEM   = 10'h002;
	localparam logic [CYC_W-1:0] CYC_COND_EXTRA = 10'h001;

	localparam logic [2:0] LEN_OP1     = 3'h1;
	localparam logic [2:0] LEN_OP2     = 3'h2;
	localparam logic [2:0] LEN_IMM     = 3'h1;
	localparam logic [2:0] LEN_FAR     = 3'h3;
	localparam logic [2:0] LEN_CTX     = 3'h7;
	localparam logic [2:0] LEN_CTX_ARG = 3'h5;

	localparam logic [CYC_W-1:0] CNT_RST = 10'h000;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_STORE_CONTROL_REG,
		OP_STORE_PROG_CTR,
		OP_STORE_CONTEXT,
		OP_STORE_EXT_FAR,
		OP_STORE_EXT_DSP20,
		OP_STORE_EXT_ADDR_PAIR,
		OP_STORE_IF_NONZERO,
		OP_STORE_IF_ZERO
	} sidec_op_e;

	typedef enum logic [3:0] {
		CR_NONE,
		CR_VECTOR_BASE_LOW,
		CR_VECTOR_BASE_HIGH,
		CR_PROCESSOR_FLAGS,
		CR_INTERRUPT_STACK_PTR,
		CR_USER_STACK_PTR,
		CR_STATIC_BASE,
		CR_FRAME_BASE
	} sidec_creg_e;

	typedef struct packed {
		sidec_op_e        op;
		sidec_creg_e      creg;
		logic             size_word;
		logic [3:0]       src_code;
		logic [3:0]       dst_code;
		logic [2:0]       len;
		logic [CYC_W-1:0] cycles;
		logic [2:0]       src_ofs;
		logic [2:0]       src_ext;
		logic [2:0]       dst_ofs;
		logic [2:0]       dst_ext;
		logic             writes;
		logic             illegal;
	} sidec_dec_s;

	function automatic logic [2:0] ext_bytes(input logic [3:0] code);
		logic [2:0] n;
		n = 3'h0;
		if (code == 4'hf || code[3:2] == 2'b11) begin
			n = 3'h2;
		end else if (code[3:2] == 2'b10) begin
			n = 3'h1;
		end
		return n;
	endfunction

	function automatic logic is_mem(input logic [3:0] code);
		return code >= CODE_FIRST_MEM;
	endfunction

endpackage

// ---- core/sidec_core.sv ----
// Summary of operation
// (RULE1) Two-byte control store opcode, 3+4 field
// (RULE2) Codes 1-3: vector base halves, flags
// (RULE3) Codes 4-7: stacks, static, frame base
// (RULE4) Source code zero is reserved, flagged
// (RULE5) Control store lengths and cycle counts
// (RULE6) Counter store destinations; some not selectable
// (RULE7) Counter store lengths and cycle counts
// (RULE8) Context store: seven bytes, 11+2m cycles
// (RULE9) Far absolute store lengths and cycles
// (RULE10) Displaced far store matches absolute timing
// (RULE11) Address pair store lengths and cycles
// (RULE12) Store-if-nonzero: extra cycle when Z clear
// (RULE13) Store-if-zero: extra cycle when Z set
// (RULE14) Short three-bit destination codes, immediate follows
// (RULE15) Write only when zero condition holds
// (RULE16) Source extension bytes before destination bytes
`timescale 1ns/1ps
`default_nettype none

module sidec_core (
	input  wire logic                    clk_sys_i,
	input  wire logic                    nrst_i,
	input  wire logic                    instr_valid_i,
	input  wire logic [7:0]              instr_b0_i,
	input  wire logic [7:0]              instr_b1_i,
	input  wire logic                    zero_flag_i,
	input  wire logic [sidec_pkg::CTX_W-1:0] ctx_count_i,
	output logic                         instr_ready_o,
	output logic                         dec_valid_o,
	output sidec_pkg::sidec_dec_s        dec_o,
	output logic                         busy_o,
	output logic                         done_o,
	output logic                         write_en_o
);
	import sidec_pkg::*;

	sidec_dec_s       dec_n;
	sidec_dec_s       dec_d;
	sidec_dec_s       dec_q;
	logic             dv_d;
	logic             dv_q;
	logic [CYC_W-1:0] cnt_d;
	logic [CYC_W-1:0] cnt_q;
	logic             accept;
	logic             cond_true;
	logic [2:0]       cext;

	assign instr_ready_o = (cnt_q == CNT_RST);
	assign accept        = instr_valid_i && instr_ready_o;

	always_comb begin
		dec_n         = '0;
		dec_n.op      = OP_NONE;
		dec_n.creg    = CR_NONE;
		dec_n.illegal = 1'b1;
		dec_n.src_ofs = LEN_OP2;
		dec_n.dst_ofs = LEN_OP2;
		cond_true     = 1'b0;
		cext          = 3'h0;
		// (RULE1) control store opcode
		if (instr_b0_i == OP_CTRL_B0 && instr_b1_i[7] == OP_CTRL_B1_MSB) begin
			dec_n.op       = OP_STORE_CONTROL_REG;
			dec_n.src_code = {1'b0, instr_b1_i[6:4]};
			dec_n.dst_code = instr_b1_i[3:0];
			// (RULE2) (RULE3) register select
			case (instr_b1_i[6:4])
				CREG_VEC_LOW:  dec_n.creg = CR_VECTOR_BASE_LOW;
				CREG_VEC_HIGH: dec_n.creg = CR_VECTOR_BASE_HIGH;
				CREG_FLAGS:    dec_n.creg = CR_PROCESSOR_FLAGS;
				CREG_INT_STK:  dec_n.creg = CR_INTERRUPT_STACK_PTR;
				CREG_USR_STK:  dec_n.creg = CR_USER_STACK_PTR;
				CREG_STATIC:   dec_n.creg = CR_STATIC_BASE;
				CREG_FRAME:    dec_n.creg = CR_FRAME_BASE;
				default:       dec_n.creg = CR_NONE;
			endcase
			// (RULE4) reserved source code
			dec_n.illegal = (instr_b1_i[6:4] == CREG_RSVD);
			// (RULE5) length and cycles
			dec_n.dst_ext = ext_bytes(instr_b1_i[3:0]);
			dec_n.len     = LEN_OP2 + dec_n.dst_ext;
			dec_n.cycles  = is_mem(instr_b1_i[3:0]) ? CYC_CTRL_MEM : CYC_CTRL_REG;
			dec_n.writes  = 1'b1;
		end else if (instr_b0_i == OP_CTX_B0 && instr_b1_i == OP_CTX_B1) begin
			// (RULE8) context store timing
			dec_n.op      = OP_STORE_CONTEXT;
			dec_n.illegal = 1'b0;
			dec_n.dst_ext = LEN_CTX_ARG;
			dec_n.len     = LEN_CTX;
			dec_n.cycles  = CYC_CTX_BASE + CYC_CTX_PER * CYC_W'(ctx_count_i);
			dec_n.writes  = 1'b1;
		end else if (instr_b0_i == OP_PROG_B0 && instr_b1_i[7:4] == OP_PROG_B1_HI) begin
			dec_n.op       = OP_STORE_PROG_CTR;
			dec_n.dst_code = instr_b1_i[3:0];
			// (RULE6) pair or memory destinations only
			dec_n.illegal  = !is_mem(instr_b1_i[3:0])
				&& instr_b1_i[3:0] != DST_DATA_PAIR_LOW
				&& instr_b1_i[3:0] != DST_DATA_PAIR_HIGH
				&& instr_b1_i[3:0] != DST_ADDRESS_PAIR;
			// (RULE7) length and cycles
			dec_n.dst_ext = ext_bytes(instr_b1_i[3:0]);
			dec_n.len     = LEN_OP2 + dec_n.dst_ext;
			dec_n.cycles  = is_mem(instr_b1_i[3:0]) ? CYC_PROG_MEM : CYC_PROG_REG;
			dec_n.writes  = 1'b1;
		end else if (instr_b0_i[7:1] == OP_EXT_B0_HI
			&& (instr_b1_i[7:4] == OP_EXT_FAR || instr_b1_i[7:4] == OP_EXT_DSP20
			|| instr_b1_i[7:4] == OP_EXT_PAIR)) begin
			dec_n.illegal   = 1'b0;
			dec_n.size_word = instr_b0_i[0];
			dec_n.src_code  = instr_b1_i[3:0];
			dec_n.src_ext   = ext_bytes(instr_b1_i[3:0]);
			// (RULE16) source bytes come first
			dec_n.dst_ofs   = LEN_OP2 + dec_n.src_ext;
			dec_n.cycles    = is_mem(instr_b1_i[3:0]) ? CYC_EXT_MEM : CYC_EXT_REG;
			dec_n.writes    = 1'b1;
			if (instr_b1_i[7:4] == OP_EXT_PAIR) begin
				// (RULE11) pair-addressed form
				dec_n.op  = OP_STORE_EXT_ADDR_PAIR;
				dec_n.len = LEN_OP2 + dec_n.src_ext;
			end else begin
				// (RULE9) (RULE10) far field after source
				dec_n.op      = (instr_b1_i[7:4] == OP_EXT_FAR) ? OP_STORE_EXT_FAR
					: OP_STORE_EXT_DSP20;
				dec_n.dst_ext = LEN_FAR;
				dec_n.len     = LEN_OP2 + dec_n.src_ext + LEN_FAR;
			end
		end else if (instr_b0_i[7:3] == OP_NZ_HI || instr_b0_i[7:3] == OP_Z_HI) begin
			dec_n.op       = (instr_b0_i[7:3] == OP_NZ_HI) ? OP_STORE_IF_NONZERO
				: OP_STORE_IF_ZERO;
			dec_n.dst_code = {1'b0, instr_b0_i[2:0]};
			// (RULE14) short destination codes
			dec_n.illegal  = instr_b0_i[2:0] < CD_ACC_HIGH;
			if (instr_b0_i[2:0] == CD_NEAR_ABS) begin
				cext = 3'h2;
			end else if (instr_b0_i[2:0] == CD_STATIC_DSP || instr_b0_i[2:0] == CD_FRAME_DSP) begin
				cext = 3'h1;
			end
			dec_n.src_ofs = LEN_OP1;
			dec_n.src_ext = LEN_IMM;
			dec_n.dst_ofs = LEN_OP1 + LEN_IMM;
			dec_n.dst_ext = cext;
			dec_n.len     = LEN_OP1 + LEN_IMM + cext;
			// (RULE12) (RULE13) zero flag condition
			cond_true     = (instr_b0_i[7:3] == OP_NZ_HI) ? !zero_flag_i : zero_flag_i;
			dec_n.cycles  = ((instr_b0_i[2:0] >= CD_STATIC_DSP) ? CYC_COND_MEM : CYC_COND_REG)
				+ (cond_true ? CYC_COND_EXTRA : CNT_RST);
			// (RULE15) write only when condition holds
			dec_n.writes  = cond_true;
		end
	end

	// Illegal opcodes are reported but never occupy the timing counter.
	always_comb begin
		dec_d = dec_q;
		dv_d  = accept;
		cnt_d = cnt_q;
		if (cnt_q != CNT_RST) begin
			cnt_d = cnt_q - 10'h001;
		end
		if (accept) begin
			dec_d = dec_n;
			if (!dec_n.illegal) begin
				cnt_d = dec_n.cycles;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dec_q <= '0;
			dv_q  <= 1'b0;
			cnt_q <= CNT_RST;
		end else begin
			dec_q <= dec_d;
			dv_q  <= dv_d;
			cnt_q <= cnt_d;
		end
	end

	assign dec_o       = dec_q;
	assign dec_valid_o = dv_q;
	assign busy_o      = (cnt_q != CNT_RST);
	assign done_o      = (cnt_q == 10'h001);
	assign write_en_o  = done_o && dec_q.writes;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	sequence s_take_ctrl;
		accept && instr_b0_i == OP_CTRL_B0 && instr_b1_i[7];
	endsequence

	sequence s_single_cycle;
		accept && !dec_n.illegal && dec_n.cycles == 10'h001;
	endsequence

	sequence s_take_ext;
		accept && instr_b0_i[7:1] == 7'h3a;
	endsequence

	sequence s_take_short;
		accept && (instr_b0_i[7:3] == 5'h1a || instr_b0_i[7:3] == 5'h19);
	endsequence

	AST_CTRL_RSVD: assert property (s_take_ctrl ##0 instr_b1_i[6:4] == 3'h0 |=> // RULE4
		dec_valid_o && dec_o.illegal && !busy_o)
		else $error("Reserved control source not flagged.");

	AST_CTRL_FLAGS: assert property (s_take_ctrl ##0 instr_b1_i[6:4] == 3'h3 |=> // RULE2
		dec_o.creg == CR_PROCESSOR_FLAGS && !dec_o.illegal)
		else $error("Flag register source misdecoded.");

	AST_CTRL_FRAME: assert property (s_take_ctrl ##0 instr_b1_i[6:4] == 3'h7 |=> // RULE3
		dec_o.creg == CR_FRAME_BASE)
		else $error("Frame base source misdecoded.");

	AST_CTRL_ABS: assert property (s_take_ctrl ##0 instr_b1_i[3:0] == 4'hf |=> // RULE5
		dec_o.len == 3'h4 && dec_o.cycles == 10'h002)
		else $error("Control store to absolute has wrong timing.");

	AST_PROG_BAD: assert property (accept && instr_b0_i == 8'h7c && instr_b1_i == 8'hc2 |=> // RULE6
		dec_o.illegal)
		else $error("Unselectable counter destination accepted.");

	AST_PROG_MEM: assert property (accept && instr_b0_i == 8'h7c && instr_b1_i == 8'hc6 |=> // RULE7
		dec_o.len == 3'h2 && dec_o.cycles == 10'h003 ##1 busy_o [*2] ##1 !busy_o)
		else $error("Counter store to indirect memory timing wrong.");

	AST_CTX: assert property (accept && instr_b0_i == 8'h7c && instr_b1_i == 8'hf0 |=> // RULE8
		dec_o.len == 3'h7 && dec_o.cycles == 10'h00b + 10'h002 * CYC_W'($past(ctx_count_i)))
		else $error("Context store timing wrong.");

	AST_EXT_FAR: assert property (accept && instr_b0_i[7:1] == 7'h3a && instr_b1_i == 8'h0f |=> // RULE9
		dec_o.len == 3'h7 && dec_o.cycles == 10'h004 && dec_o.dst_ofs == 3'h4)
		else $error("Far store from absolute source wrong.");

	AST_COND_SKIP: assert property (accept && instr_b0_i == 8'hcb && !zero_flag_i |=> // RULE13
		!dec_o.writes && dec_o.cycles == 10'h001 ##0 done_o && !write_en_o)
		else $error("Store-if-zero wrote with zero flag clear.");

	AST_COND_NZ: assert property (accept && instr_b0_i == 8'hd7 && !zero_flag_i |=> // RULE12
		dec_o.len == 3'h4 && dec_o.cycles == 10'h003 && dec_o.writes)
		else $error("Store-if-nonzero absolute timing wrong.");

	AST_ONE_CYCLE: assert property (s_single_cycle |=> busy_o && done_o ##1 !busy_o) // RULE15
		else $error("Single-cycle store did not end on time.");

	AST_ORDER: assert property (dec_valid_o && !dec_o.illegal |-> // RULE16
		dec_o.dst_ofs == dec_o.src_ofs + dec_o.src_ext)
		else $error("Destination bytes do not follow source bytes.");

	AST_CTRL_CODES: assert property (s_take_ctrl |=> // RULE1
		{1'b1, dec_o.src_code[2:0], dec_o.dst_code} == $past(instr_b1_i))
		else $error("Control store fields misdecoded.");

	AST_CTRL_VEC_LOW: assert property (s_take_ctrl ##0 instr_b1_i[6:4] == 3'h1 |=> // RULE2
		dec_o.creg == CR_VECTOR_BASE_LOW && !dec_o.illegal)
		else $error("Vector base low source misdecoded.");

	AST_CTRL_INT_STK: assert property (s_take_ctrl ##0 instr_b1_i[6:4] == 3'h4 |=> // RULE3
		dec_o.creg == CR_INTERRUPT_STACK_PTR && !dec_o.illegal)
		else $error("Interrupt stack source misdecoded.");

	AST_CTRL_REG: assert property (s_take_ctrl ##0 instr_b1_i[3:0] < 4'h6 |=> // RULE5
		dec_o.len == 3'h2 && dec_o.cycles == 10'h001)
		else $error("Control store to register has wrong timing.");

	AST_PROG_PAIR: assert property (accept && instr_b0_i == 8'h7c && instr_b1_i == 8'hc4 |=> // RULE6
		!dec_o.illegal && dec_o.len == 3'h2 && dec_o.cycles == 10'h002)
		else $error("Counter store to address pair misdecoded.");

	AST_PROG_ABS: assert property (accept && instr_b0_i == 8'h7c && instr_b1_i == 8'hcf |=> // RULE7
		dec_o.len == 3'h4 && dec_o.cycles == 10'h003)
		else $error("Counter store to absolute timing wrong.");

	AST_EXT_REG: assert property (s_take_ext ##0 instr_b1_i == 8'h00 |=> // RULE9
		dec_o.op == OP_STORE_EXT_FAR && dec_o.len == 3'h5 && dec_o.cycles == 10'h003)
		else $error("Far store from register wrong.");

	AST_DSP20_MEM: assert property (s_take_ext ##0 instr_b1_i == 8'h16 |=> // RULE10
		dec_o.op == OP_STORE_EXT_DSP20 && dec_o.len == 3'h5 && dec_o.cycles == 10'h004)
		else $error("Displaced far store from memory wrong.");

	AST_PAIR_REG: assert property (s_take_ext ##0 instr_b1_i == 8'h20 |=> // RULE11
		dec_o.len == 3'h2 && dec_o.cycles == 10'h003 && busy_o ##1 busy_o [*2] ##1 !busy_o)
		else $error("Pair store from register timing wrong.");

	AST_PAIR_ABS: assert property (s_take_ext ##0 instr_b1_i == 8'h2f |=> // RULE11
		dec_o.len == 3'h4 && dec_o.cycles == 10'h004)
		else $error("Pair store from absolute source wrong.");

	AST_NZ_SKIP: assert property (accept && instr_b0_i == 8'hd4 && zero_flag_i |=> // RULE12
		dec_o.len == 3'h2 && dec_o.cycles == 10'h001 && done_o && !write_en_o)
		else $error("Store-if-nonzero wrote with zero flag set.");

	AST_Z_ABS: assert property (accept && instr_b0_i == 8'hcf && zero_flag_i |=> // RULE13
		dec_o.len == 3'h4 && dec_o.cycles == 10'h003 && dec_o.writes)
		else $error("Store-if-zero absolute timing wrong.");

	AST_SHORT_RSVD: assert property (s_take_short ##0 instr_b0_i[2:0] < 3'h3 |=> // RULE14
		dec_valid_o && dec_o.illegal && !busy_o)
		else $error("Unselectable short destination accepted.");

	AST_SHORT_WRITE: assert property (s_take_short ##0 instr_b0_i[2:0] > 3'h2 // RULE15
		##0 instr_b0_i[3] == zero_flag_i |=> dec_o.writes)
		else $error("Conditional store skipped a due write.");

	AST_BUSY_HOLD: assert property (busy_o && !done_o |=> busy_o && !dec_valid_o) // RULE8
		else $error("Busy ended early or decode taken while busy.");

endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
	import sidec_pkg::*;

	logic             clk_sys_i     = 1'b0;
	logic             nrst_i        = 1'b0;
	logic             instr_valid_i = 1'b0;
	logic [7:0]       instr_b0_i    = 8'h00;
	logic [7:0]       instr_b1_i    = 8'h00;
	logic             zero_flag_i   = 1'b0;
	logic [CTX_W-1:0] ctx_count_i   = 8'h00;
	logic             instr_ready_o;
	logic             dec_valid_o;
	sidec_dec_s       dec;
	logic             busy_o;
	logic             done_o;
	logic             write_en_o;
	int               errors        = 0;
	int               checks_done   = 0;
	int               cycles        = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	sidec_core u_dut (
		.clk_sys_i    (clk_sys_i),
		.nrst_i       (nrst_i),
		.instr_valid_i(instr_valid_i),
		.instr_b0_i   (instr_b0_i),
		.instr_b1_i   (instr_b1_i),
		.zero_flag_i  (zero_flag_i),
		.ctx_count_i  (ctx_count_i),
		.instr_ready_o(instr_ready_o),
		.dec_valid_o  (dec_valid_o),
		.dec_o        (dec),
		.busy_o       (busy_o),
		.done_o       (done_o),
		.write_en_o   (write_en_o)
	);

	task automatic end_sim();
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// The whole run needs under eight hundred cycles, so this ceiling only trips on a hang.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Extension bytes that a general operand code needs.
	function automatic logic [2:0] xb(input logic [3:0] c);
		return (c >= 4'hc) ? 3'h2 : ((c >= 4'h8) ? 3'h1 : 3'h0);
	endfunction

	// Keeping valid up for hold cycles after the accept probes refusal while busy.
	task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic z,
		input logic [7:0] m, input logic ill, input sidec_op_e op, input logic [2:0] len,
		input logic [9:0] cyc, input logic wr, input int hold = 0);
		int n;
		int dn;
		n = 0;
		dn = 0;
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b1;
		instr_b0_i <= b0;
		instr_b1_i <= b1;
		zero_flag_i <= z;
		ctx_count_i <= m;
		@(posedge clk_sys_i);
		if (hold == 0) instr_valid_i <= 1'b0;
		#1;
		chk(dec_valid_o, 1'b1, "decode pulse");
		chk(dec.illegal, ill, "illegal flag");
		if (ill) begin
			chk(busy_o, 1'b0, "busy on illegal");
			chk(instr_ready_o, 1'b1, "ready on illegal");
		end else begin
			chk(dec.op, op, "op");
			chk(dec.len, len, "length");
			chk(dec.cycles, cyc, "cycles");
			chk(dec.writes, wr, "writes");
			if (op == OP_STORE_EXT_FAR || op == OP_STORE_EXT_DSP20) begin
				chk(dec.dst_ofs, 3'h2 + xb(b1[3:0]), "dest offset");
			end
			while (busy_o === 1'b1 && n < 600) begin
				n++;
				if (n > 1) chk(dec_valid_o, 1'b0, "decode while busy");
				chk(instr_ready_o, 1'b0, "ready while busy");
				chk(write_en_o, done_o === 1'b1 && wr, "write strobe");
				if (done_o === 1'b1) dn = n;
				@(posedge clk_sys_i);
				if (n == hold) instr_valid_i <= 1'b0;
				#1;
			end
			chk(n, cyc, "busy length");
			chk(dn, cyc, "done position");
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_sys_i);
		chk(instr_ready_o, 1'b1, "reset ready");
		chk(dec_valid_o, 1'b0, "reset decode");
		chk(busy_o | done_o | write_en_o, 1'b0, "reset strobes");
		nrst_i <= 1'b1;
		for (int s = 1; s < 8; s++) begin
			run(8'h7b, {1'b1, 3'(s), 4'h0}, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h2,
				10'h001, 1'b1);
			chk(dec.creg, s, "control source");
		end
		run(8'h7b, 8'h80, 1'b0, 8'h00, 1'b1, OP_NONE, 3'h0, 10'h000, 1'b0);
		run(8'h7b, 8'hb6, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h2, 10'h002, 1'b1);
		run(8'h7b, 8'hb4, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h2, 10'h001, 1'b1);
		run(8'h7b, 8'hba, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h3, 10'h002, 1'b1);
		run(8'h7b, 8'hbc, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h4, 10'h002, 1'b1);
		run(8'h7b, 8'hff, 1'b0, 8'h00, 1'b0, OP_STORE_CONTROL_REG, 3'h4, 10'h002, 1'b1);
		run(8'h7c, 8'hc0, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h2, 10'h002, 1'b1);
		run(8'h7c, 8'hc1, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h2, 10'h002, 1'b1);
		run(8'h7c, 8'hc4, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h2, 10'h002, 1'b1);
		chk(dec.dst_code, 4'h4, "pair destination");
		run(8'h7c, 8'hc6, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h2, 10'h003, 1'b1);
		run(8'h7c, 8'hc9, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h3, 10'h003, 1'b1);
		run(8'h7c, 8'hcf, 1'b0, 8'h00, 1'b0, OP_STORE_PROG_CTR, 3'h4, 10'h003, 1'b1);
		for (int c = 2; c < 6; c++) begin
			if (c != 4) run(8'h7c, 8'hc0 | 8'(c), 1'b0, 8'h00, 1'b1, OP_NONE, 3'h0, 10'h000,
				1'b0);
		end
		run(8'h7c, 8'hf0, 1'b0, 8'h00, 1'b0, OP_STORE_CONTEXT, 3'h7, 10'h00b, 1'b1);
		run(8'h7c, 8'hf0, 1'b0, 8'h03, 1'b0, OP_STORE_CONTEXT, 3'h7, 10'h011, 1'b1, 5);
		run(8'h7c, 8'hf0, 1'b0, 8'hff, 1'b0, OP_STORE_CONTEXT, 3'h7, 10'h209, 1'b1);
		run(8'h74, 8'h00, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_FAR, 3'h5, 10'h003, 1'b1);
		run(8'h75, 8'h0e, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_FAR, 3'h7, 10'h004, 1'b1);
		chk(dec.size_word, 1'b1, "word size");
		chk(dec.src_code, 4'he, "far source code");
		run(8'h74, 8'h0f, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_FAR, 3'h7, 10'h004, 1'b1);
		run(8'h74, 8'h08, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_FAR, 3'h6, 10'h004, 1'b1);
		chk(dec.size_word, 1'b0, "byte size");
		run(8'h74, 8'h16, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_DSP20, 3'h5, 10'h004, 1'b1);
		chk(dec.dst_ext, 3'h3, "far field bytes");
		run(8'h74, 8'h1c, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_DSP20, 3'h7, 10'h004, 1'b1);
		run(8'h74, 8'h20, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_ADDR_PAIR, 3'h2, 10'h003, 1'b1);
		run(8'h74, 8'h26, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_ADDR_PAIR, 3'h2, 10'h004, 1'b1);
		run(8'h74, 8'h2f, 1'b0, 8'h00, 1'b0, OP_STORE_EXT_ADDR_PAIR, 3'h4, 10'h004, 1'b1);
		run(8'hd3, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_NONZERO, 3'h2, 10'h002, 1'b1);
		run(8'hd4, 8'h55, 1'b1, 8'h00, 1'b0, OP_STORE_IF_NONZERO, 3'h2, 10'h001, 1'b0);
		run(8'hd5, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_NONZERO, 3'h3, 10'h003, 1'b1);
		run(8'hd7, 8'h55, 1'b1, 8'h00, 1'b0, OP_STORE_IF_NONZERO, 3'h4, 10'h002, 1'b0);
		run(8'hd7, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_NONZERO, 3'h4, 10'h003, 1'b1);
		run(8'hcb, 8'h55, 1'b1, 8'h00, 1'b0, OP_STORE_IF_ZERO, 3'h2, 10'h002, 1'b1);
		run(8'hcc, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_ZERO, 3'h2, 10'h001, 1'b0);
		run(8'hce, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_ZERO, 3'h3, 10'h002, 1'b0);
		run(8'hcf, 8'h55, 1'b1, 8'h00, 1'b0, OP_STORE_IF_ZERO, 3'h4, 10'h003, 1'b1);
		chk(dec.dst_ofs, 3'h2, "immediate before dest");
		chk(dec.dst_code, 4'h7, "short dest code");
		run(8'hcb, 8'h55, 1'b0, 8'h00, 1'b0, OP_STORE_IF_ZERO, 3'h2, 10'h001, 1'b0);
		run(8'hd0, 8'h55, 1'b0, 8'h00, 1'b1, OP_NONE, 3'h0, 10'h000, 1'b0);
		run(8'hca, 8'h55, 1'b1, 8'h00, 1'b1, OP_NONE, 3'h0, 10'h000, 1'b0);
		run(8'h00, 8'h00, 1'b0, 8'h00, 1'b1, OP_NONE, 3'h0, 10'h000, 1'b0);
		end_sim();
	end
endmodule

`default_nettype wire
